// ---- edw_pkg.sv ----
// Functional notes
// [R1] Walker is a memory master; the communications area spans 256 bytes.
// [R2] Software reaches the walker's own registers as a bus target.
// [R3] Transfer buffers hold 0 to 8192 bytes; packets at most 1023 bytes.
// [R4] Transfers queued on one endpoint are serviced in first-in order.
// [R5] Software places endpoint descriptors on 16-byte boundaries, 16-byte units.
// [R6] A queued transfer on a visited endpoint is performed during the walk.
// [R7] Software sets skip before changing a queue head link.
// [R8] Direction 01 is OUT, 10 is IN, 00 and 11 defer to the transfer.
// [R9] Speed bit zero means full speed, one means low speed.
// [R10] A skipped endpoint gets no queue read and no token.
// [R11] Format bit zero selects general layout, one selects isochronous layout.
// [R12] OUT or SETUP packet length is the lesser of largest size and remaining.
// [R13] IN packet length is whatever the endpoint sends.
// [R14] Equal head and tail links mean the queue is empty.
// [R15] A transfer ending in error sets the endpoint's halted flag.
// [R16] Retiring a transfer writes its last toggle into the toggle carry; for isochronous format the walker writes back the old carry instead.
// [R17] Head link selects the next transfer and is advanced by the walker.
// [R18] A nonzero following link is followed; zero ends the list.
// [R19] Tokens carry function address and endpoint number from the descriptor.
// [R20] Word 0 packs address, endpoint, direction, speed, skip, format, size.
// [R21] Words 1 to 3 are tail, head with halted and carry, following link.
// [R22] A halted endpoint is not serviced until software clears halted.
package edw_pkg;
	localparam logic [7:0]  edw_reg_ctrl      = 8'h00;
	localparam logic [7:0]  edw_reg_list_head = 8'h04;
	localparam logic [7:0]  edw_reg_area      = 8'h08;
	localparam logic [7:0]  edw_reg_status    = 8'h0c;
	localparam logic [7:0]  edw_reg_current   = 8'h10;
	localparam logic [7:0]  edw_reg_count     = 8'h14;
	localparam logic [31:0] edw_link_mask     = 32'hffff_fff0;
	localparam logic [31:0] edw_area_mask     = 32'hffff_ff00;
	localparam logic [31:0] edw_word_step     = 32'h0000_0004;
	localparam logic [31:0] edw_head_word_off = 32'h0000_0008;
	localparam logic [13:0] edw_buf_max       = 14'h2000;
	localparam logic [10:0] edw_pkt_max       = 11'h03ff;
	localparam logic [1:0]  edw_dir_out       = 2'h1;
	localparam logic [1:0]  edw_dir_in        = 2'h2;
	localparam int          edw_ctrl_run_bit  = 0;

	typedef struct packed {
		logic [4:0]  unused_hi;
		logic [10:0] largest_packet_bytes;
		logic        format_iso;
		logic        skip;
		logic        low_speed;
		logic [1:0]  direction;
		logic [3:0]  endpoint_number;
		logic [6:0]  function_address;
	} edw_word0_t;

	typedef enum logic [1:0] {edw_tok_setup, edw_tok_out, edw_tok_in, edw_tok_defer} edw_tok_t;

	typedef struct packed {
		logic [6:0]  function_address;
		logic [3:0]  endpoint_number;
		edw_tok_t    token;
		logic        low_speed;
		logic        format_iso;
		logic [10:0] largest_packet_bytes;
		logic [31:0] queue_head_link;
		logic        toggle_carry;
	} edw_job_t;

	typedef struct packed {
		logic        error;
		logic        last_toggle;
		logic [31:0] next_link;
	} edw_done_t;
endpackage : edw_pkg

// ---- edw_word_store.sv ----
`timescale 1ns/1ns
// Holds the four words of the descriptor being worked on; read data registered.
module edw_word_store
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rstn,
	// Write side
	input  wire logic        wr_en,
	input  wire logic [1:0]  wr_idx,
	input  wire logic [31:0] wr_data,
	// Read side
	input  wire logic [1:0]  rd_idx,
	output logic      [31:0] rd_data
);
	logic [31:0] mem [4];

	always_ff @(posedge core_clk)
	begin
		if (wr_en)
		begin
			mem[wr_idx] <= wr_data;
		end
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rd_data <= 32'h0000_0000;
		end
		else
		begin
			rd_data <= (wr_en && wr_idx == rd_idx) ? wr_data : mem[rd_idx];
		end
	end
endmodule : edw_word_store

// ---- edw_walker.sv ----
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ns
module edw_walker
	import edw_pkg::*;
(
	// Clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 rstn,
	// Register port
	input  wire logic [7:0]           reg_addr,
	input  wire logic [31:0]          reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic      [31:0]          reg_rdata,
	// Memory master port
	output logic                      mem_req,
	output logic                      mem_we,
	output logic      [31:0]          mem_addr,
	output logic      [31:0]          mem_wdata,
	input  wire logic                 mem_ack,
	input  wire logic [31:0]          mem_rdata,
	// Transfer engine
	output logic                      job_valid,
	output edw_pkg::edw_job_t         job,
	input  wire logic                 job_done,
	input  wire edw_pkg::edw_done_t   done_info,
	// Status
	output logic                      walk_busy
);
	import edw_pkg::*;

	typedef enum logic [2:0] {s_idle, s_fetch, s_decide, s_job, s_wait, s_write, s_next} edw_state_t;

	edw_state_t  state;
	logic        run;
	logic [31:0] list_head;
	logic [31:0] area_base;
	logic [31:0] cur_desc;
	logic [1:0]  word_idx;
	logic [15:0] serviced;
	logic        halt_seen;
	logic [31:0] head_new;
	logic [31:0] w0, w1, w2, w3;
	logic [1:0]  rd_idx;
	logic [31:0] rd_word;
	logic        store_we;

	function automatic edw_tok_t decode_dir(input logic [1:0] d);
		unique case (d)
			edw_dir_out: return edw_tok_out;
			edw_dir_in:  return edw_tok_in;
			default:     return edw_tok_defer;
		endcase
	endfunction : decode_dir

	function automatic logic [31:0] link_of(input logic [31:0] w);
		return w & edw_link_mask;
	endfunction : link_of

	assign store_we = (state == s_fetch) && mem_ack;
	assign rd_idx = 2'h0;

	edw_word_store u_store
	(
		.core_clk (core_clk),
		.rstn     (rstn),
		.wr_en    (store_we),
		.wr_idx   (word_idx),
		.wr_data  (mem_rdata),
		.rd_idx   (rd_idx),
		.rd_data  (rd_word)
	);

	// Shadow copies of the words, ready for decode the cycle after arrival.
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			w0 <= 32'h0000_0000;
			w1 <= 32'h0000_0000;
			w2 <= 32'h0000_0000;
			w3 <= 32'h0000_0000;
		end
		else if (store_we)
		begin
			unique case (word_idx)
				2'h0: w0 <= mem_rdata;
				2'h1: w1 <= mem_rdata;
				2'h2: w2 <= mem_rdata;
				2'h3: w3 <= mem_rdata;
			endcase
		end
	end

	edw_word0_t f0;
	assign f0 = edw_word0_t'(w0); // see [R20]

	logic q_empty;
	logic q_halted;
	assign q_empty  = link_of(w1) == link_of(w2);           // see [R14] see [R21]
	assign q_halted = w2[0];                                 // see [R21]

	// Register writes.
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			run       <= 1'b0;
			list_head <= 32'h0000_0000;
			area_base <= 32'h0000_0000;
		end
		else if (reg_wr)
		begin
			// Registers answer as a bus target.  see [R2]
			unique case (reg_addr)
				edw_reg_ctrl:      run       <= reg_wdata[edw_ctrl_run_bit];
				edw_reg_list_head: list_head <= link_of(reg_wdata); // see [R5]
				edw_reg_area:      area_base <= reg_wdata & edw_area_mask; // see [R1]
				default:           ;
			endcase
		end
	end

	// Register reads, one cycle later.
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			reg_rdata <= 32'h0000_0000;
		end
		else if (reg_rd)
		begin
			unique case (reg_addr)
				edw_reg_ctrl:      reg_rdata <= {31'h0000_0000, run};
				edw_reg_list_head: reg_rdata <= list_head;
				edw_reg_area:      reg_rdata <= area_base;
				edw_reg_status:    reg_rdata <= {29'h0000_0000, halt_seen, rd_word[14], walk_busy};
				edw_reg_current:   reg_rdata <= cur_desc;
				edw_reg_count:     reg_rdata <= {16'h0000, serviced};
				default:           reg_rdata <= 32'h0000_0000;
			endcase
		end
		else
		begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	assign walk_busy = state != s_idle;

	// Walk state machine.
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state    <= s_idle;
			cur_desc <= 32'h0000_0000;
			word_idx <= 2'h0;
			head_new <= 32'h0000_0000;
		end
		else
		begin
			unique case (state)
				s_idle:
				begin
					if (run && list_head != 32'h0000_0000)
					begin
						cur_desc <= list_head;
						word_idx <= 2'h0;
						state    <= s_fetch;
					end
				end
				s_fetch:
				begin
					if (mem_ack)
					begin
						word_idx <= word_idx + 2'h1;
						if (word_idx == 2'h3)
						begin
							state <= s_decide;
						end
					end
				end
				s_decide:
				begin
					// Skip, halted and empty all pass on without a token.  see [R10] see [R22]
					if (f0.skip || q_halted || q_empty)
					begin
						state <= s_next;
					end
					else
					begin
						state <= s_job; // see [R6]
					end
				end
				s_job:
				begin
					state <= s_wait;
				end
				s_wait:
				begin
					if (job_done)
					begin
						// Head moves to the next queued transfer; halted and carry refreshed.
						head_new <= link_of(done_info.next_link)           // see [R17] see [R4]
							| {30'h0000_0000,
							   f0.format_iso ? w2[1] : done_info.last_toggle, // see [R16]
							   done_info.error};                                // see [R15]
						state    <= s_write;
					end
				end
				s_write:
				begin
					if (mem_ack)
					begin
						state <= s_next;
					end
				end
				s_next:
				begin
					if (link_of(w3) != 32'h0000_0000 && run) // see [R18]
					begin
						cur_desc <= link_of(w3);
						word_idx <= 2'h0;
						state    <= s_fetch;
					end
					else
					begin
						state <= s_idle;
					end
				end
				default: state <= s_idle;
			endcase
		end
	end

	// Counts written-back head words and latches a halt until software writes the status register.
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			serviced  <= 16'h0000;
			halt_seen <= 1'b0;
		end
		else
		begin
			if (state == s_write && mem_ack)
			begin
				serviced <= serviced + 16'h0001;
			end
			if (state == s_write && mem_ack && head_new[0])
			begin
				halt_seen <= 1'b1;
			end
			else if (reg_wr && reg_addr == edw_reg_status)
			begin
				halt_seen <= 1'b0;
			end
		end
	end

	// Memory master: reads four words, writes back the head word.  see [R1]
	assign mem_req   = (state == s_fetch) || (state == s_write);
	assign mem_we    = state == s_write;
	assign mem_addr  = (state == s_write) ? cur_desc + edw_head_word_off
	                                      : cur_desc + edw_word_step * {30'h0, word_idx};
	assign mem_wdata = head_new;

	// Transfer request built from the descriptor.
	assign job_valid = state == s_job;
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			job <= '0;
		end
		else if (state == s_decide)
		begin
			job.function_address     <= f0.function_address;     // see [R19]
			job.endpoint_number      <= f0.endpoint_number;      // see [R19]
			job.token                <= decode_dir(f0.direction); // see [R8]
			job.low_speed            <= f0.low_speed;            // see [R9]
			job.format_iso           <= f0.format_iso;           // see [R11]
			// Engine sends min(size, remaining) out and takes any in length.  see [R12] see [R13] see [R3]
			job.largest_packet_bytes <= (f0.largest_packet_bytes > edw_pkt_max)
				? edw_pkt_max : f0.largest_packet_bytes;
			job.queue_head_link      <= link_of(w2);             // see [R17]
			job.toggle_carry         <= w2[1];
		end
	end

	size_clamp_a: assert property (@(posedge core_clk) disable iff (!rstn) // see [R12]
		job_valid |-> job.largest_packet_bytes <= edw_pkt_max)
		else $error("packet size above limit");

	skip_no_token_a: assert property (@(posedge core_clk) disable iff (!rstn) // see [R10]
		(state == s_decide && f0.skip) |=> !job_valid)
		else $error("token issued to skipped endpoint");

	empty_no_token_a: assert property (@(posedge core_clk) disable iff (!rstn) // see [R14]
		(state == s_decide && q_empty) |=> state == s_next)
		else $error("empty queue serviced");

	halted_no_token_a: assert property (@(posedge core_clk) disable iff (!rstn) // see [R22]
		(state == s_decide && q_halted) |=> !job_valid)
		else $error("halted endpoint serviced");

	job_follows_a: assert property (@(posedge core_clk) disable iff (!rstn) // see [R6]
		(state == s_decide && !f0.skip && !q_halted && !q_empty) |=> job_valid)
		else $error("pending transfer not started");

	dir_decode_a: assert property (@(posedge core_clk) disable iff (!rstn) // see [R8]
		(state == s_decide && f0.direction == edw_dir_in) |=> job.token == edw_tok_in)
		else $error("direction decode wrong");

	error_halts_a: assert property (@(posedge core_clk) disable iff (!rstn) // see [R15]
		(state == s_wait && job_done && done_info.error) |=> head_new[0])
		else $error("error did not halt");

	list_end_a: assert property (@(posedge core_clk) disable iff (!rstn) // see [R18]
		(state == s_next && link_of(w3) == 32'h0000_0000) |=> state == s_idle)
		else $error("walk passed list end");

	addr_pass_a: assert property (@(posedge core_clk) disable iff (!rstn) // see [R19]
		job_valid |-> job.function_address == $past(f0.function_address, 1))
		else $error("token address mismatch");

	head_write_a: assert property (@(posedge core_clk) disable iff (!rstn) // see [R17]
		(state == s_write) |-> (mem_we && mem_addr == cur_desc + edw_head_word_off))
		else $error("head word written to wrong place");

	fifo_head_a: assert property (@(posedge core_clk) disable iff (!rstn) // see [R4]
		job_valid |-> job.queue_head_link == link_of(w2))
		else $error("transfer not taken from queue head");

	carry_write_a: assert property (@(posedge core_clk) disable iff (!rstn) // see [R16]
		(state == s_wait && job_done && !f0.format_iso) |=> head_new[1] == $past(done_info.last_toggle))
		else $error("toggle carry not written back");

	list_follow_a: assert property (@(posedge core_clk) disable iff (!rstn) // see [R18]
		(state == s_next && run && link_of(w3) != 32'h0000_0000)
		|=> (state == s_fetch && cur_desc == link_of($past(w3))))
		else $error("following descriptor not fetched");
endmodule : edw_walker

// ---- edw_mem_model.sv ----
`timescale 1ns/1ns
// Memory holding a five-entry descriptor list; every other word is answered two cycles late.
module edw_mem_model
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rstn,
	// Memory slave port
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic [31:0] mem_addr,
	input  wire logic [31:0] mem_wdata,
	output logic             mem_ack,
	output logic      [31:0] mem_rdata,
	// Write observation
	output logic      [7:0]  wr_count,
	output logic      [31:0] last_waddr,
	output logic      [31:0] last_wdata
);
	localparam logic [31:0] edw_list [20] = '{
		32'h0008_4001, 32'h0000_0310, 32'h0000_0300, 32'h0000_0110,
		32'h07ff_0985, 32'h0000_0500, 32'h0000_0402, 32'h0000_0120,
		32'h0008_3101, 32'h0000_0610, 32'h0000_0600, 32'h0000_0130,
		32'h0040_9fff, 32'h0000_0800, 32'h0000_0702, 32'h0000_0140,
		32'h03ff_0010, 32'h0000_0910, 32'h0000_0900, 32'h0000_0000};
	logic [31:0] mem [0:1023];
	logic [1:0]  wait_cnt;
	logic        slow;

	initial
	begin
		// Four-word descriptors on 16-byte boundaries from 0x100.
		// The entry at 0x100 stays skipped, as software leaves it while editing its head.
		for (int i = 0; i < 20; i++)
			mem[64+i] = edw_list[i];
	end

	// Read data outside an answer is inverted each cycle except while a request waits, so stale values do not pass.
	always @(posedge core_clk or negedge rstn)
		if (!rstn)
		begin
			mem_ack    <= 1'b0;
			mem_rdata  <= 32'h0000_0000;
			wait_cnt   <= 2'h0;
			slow       <= 1'b0;
			wr_count   <= 8'h00;
			last_waddr <= 32'h0000_0000;
			last_wdata <= 32'h0000_0000;
		end
		else if (mem_ack)
		begin
			mem_ack   <= 1'b0;
			mem_rdata <= ~mem_rdata;
		end
		else if (mem_req && wait_cnt != 2'h0)
			wait_cnt <= wait_cnt - 2'h1;
		else if (mem_req)
		begin
			mem_ack  <= 1'b1;
			slow     <= ~slow;
			wait_cnt <= slow ? 2'h0 : 2'h2;
			if (mem_we)
			begin
				mem[mem_addr[11:2]] <= mem_wdata;
				wr_count            <= wr_count + 8'h01;
				last_waddr          <= mem_addr;
				last_wdata          <= mem_wdata;
			end
			else
				mem_rdata <= mem[mem_addr[11:2]];
		end
		else
			mem_rdata <= ~mem_rdata;
endmodule : edw_mem_model

// ---- edw_walker_bench.sv ----
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
	$display("MISMATCH %0t %h %h", $time, (g), (e)); end end
module edw_walker_bench;
	import edw_pkg::*;
	typedef struct packed {
		edw_job_t    job;
		edw_done_t   done;
		logic [31:0] wa;
		logic [31:0] wd;
	} edw_row_t;
	logic        core_clk, rstn, reg_wr, reg_rd, mem_req, mem_we, mem_ack;
	logic        job_valid, job_done, walk_busy;
	logic [7:0]  reg_addr, wr_count, w;
	logic [31:0] reg_wdata, reg_rdata, mem_addr, mem_wdata, mem_rdata;
	logic [31:0] last_waddr, last_wdata, d;
	edw_job_t    job;
	edw_done_t   done_info;
	edw_row_t    rows [5];
	int          errors, check_count, n;

	edw_walker u_edw_walker (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata), .job_valid(job_valid), .job(job),
		.job_done(job_done), .done_info(done_info), .walk_busy(walk_busy));
	edw_mem_model u_edw_mem_model (.core_clk(core_clk), .rstn(rstn), .mem_req(mem_req),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata), .wr_count(wr_count), .last_waddr(last_waddr),
		.last_wdata(last_wdata));

	task automatic complete_run;
		if (errors == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd

	// Waits for a job (0), a memory write (1) or an idle walker (2).
	task automatic wait_for(input int what);
		for (n = 0; n < 2000; n++)
		begin
			@(posedge core_clk);
			#1;
			if (what == 0 && job_valid === 1'b1)
				break;
			if (what == 1 && wr_count !== w)
				break;
			if (what == 2 && walk_busy === 1'b0)
				break;
		end
		if (n == 2000)
		begin
			errors++;
			complete_run;
		end
	endtask : wait_for

	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	initial
	begin
		rstn = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		job_done = 1'b0;
		done_info = '0;
		errors = 0;
		check_count = 0;
		rows[0] = '{'{7'h05, 4'h3, edw_tok_out, 1'b0, 1'b0, 11'h3ff, 32'h0000_0400, 1'b1},
			'{1'b1, 1'b0, 32'h0000_0410}, 32'h0000_0118, 32'h0000_0411};
		rows[1] = '{'{7'h01, 4'h2, edw_tok_in, 1'b1, 1'b0, 11'h008, 32'h0000_0600, 1'b0},
			'{1'b0, 1'b1, 32'h0000_0610}, 32'h0000_0128, 32'h0000_0612};
		rows[2] = '{'{7'h7f, 4'hf, edw_tok_defer, 1'b0, 1'b1, 11'h040, 32'h0000_0700, 1'b1},
			'{1'b0, 1'b0, 32'h0000_07f0}, 32'h0000_0138, 32'h0000_07f2};
		rows[3] = '{'{7'h10, 4'h0, edw_tok_defer, 1'b0, 1'b0, 11'h3ff, 32'h0000_0900, 1'b0},
			'{1'b0, 1'b1, 32'h0000_0910}, 32'h0000_0148, 32'h0000_0912};
		rows[4] = '{'{7'h7f, 4'hf, edw_tok_defer, 1'b0, 1'b1, 11'h040, 32'h0000_07f0, 1'b1},
			'{1'b0, 1'b0, 32'h0000_0800}, 32'h0000_0138, 32'h0000_0802};
		repeat (6) @(posedge core_clk);
		`CHK({mem_req, job_valid, walk_busy}, 3'h0)
		rstn <= 1'b1;
		rd(edw_reg_ctrl);
		`CHK(d, 32'h0000_0000)
		wr(edw_reg_list_head, 32'h0000_0105);
		rd(edw_reg_list_head);
		`CHK(d, 32'h0000_0100)
		wr(edw_reg_area, 32'h0000_01ff);
		rd(edw_reg_area);
		`CHK(d, 32'h0000_0100)
		rd(8'h20);
		`CHK(d, 32'h0000_0000)
		wr(edw_reg_ctrl, 32'h0000_0001);
		// Second pass finds the endpoint at 0x110 halted and two queues emptied.
		for (int i = 0; i < 5; i++)
		begin
			if (i == 4)
			begin
				wr(edw_reg_ctrl, 32'h0000_0000);
				wait_for(2);
				wr(edw_reg_ctrl, 32'h0000_0001);
			end
			wait_for(0);
			`CHK(job, rows[i].job)
			rd(edw_reg_current);
			`CHK(d, rows[i].wa - edw_head_word_off)
			w = wr_count;
			@(posedge core_clk);
			job_done  <= 1'b1;
			done_info <= rows[i].done;
			@(posedge core_clk);
			job_done <= 1'b0;
			wait_for(1);
			`CHK(last_waddr, rows[i].wa)
			`CHK(last_wdata, rows[i].wd)
		end
		rd(edw_reg_status);
		`CHK(d[2], 1'b1)
		wr(edw_reg_ctrl, 32'h0000_0000);
		wait_for(2);
		wr(edw_reg_status, 32'h0000_0000);
		rd(edw_reg_status);
		`CHK(d[2], 1'b0)
		rd(edw_reg_count);
		`CHK(d, 32'h0000_0005)
		// A reset in mid-walk clears the registers and parks the walker.
		wr(edw_reg_ctrl, 32'h0000_0001);
		@(posedge core_clk);
		rstn <= 1'b0;
		@(posedge core_clk);
		#1;
		`CHK({mem_req, job_valid, walk_busy}, 3'h0)
		@(posedge core_clk);
		rstn <= 1'b1;
		rd(edw_reg_list_head);
		`CHK(d, 32'h0000_0000)
		rd(edw_reg_ctrl);
		`CHK(d, 32'h0000_0000)
		complete_run;
	end
endmodule : edw_walker_bench
